// ---- shared/regctl_regs.svh ----
// register offsets, field positions, reset values and codes for the
// regulator control and programming status block.
// assumes inclusion by bare name from any design or bench file.
`ifndef REGCTL_REGS_SVH
`define REGCTL_REGS_SVH

// register offsets (byte addresses on the plain register port)
`define REGCTL_ADDR_W 8
`define OFS_REGULATOR_CONTROL 8'h00
`define OFS_OTP_PROGRAM_PRECHECK 8'h01
`define OFS_OTP_PROGRAM_OUTCOME 8'h02
`define OFS_FAIL_ADDR_LO 8'h03
`define OFS_FAIL_ADDR_HI 8'h04
`define OFS_PROGRAM_CTRL 8'h05
`define OFS_IRQ_STATUS 8'h06
`define OFS_IRQ_MASK 8'h07

// regulator control fields
`define RC_LDO_A_ON 0
`define RC_LDO_A_LSB 1
`define RC_LDO_B_ON 4
`define RC_LDO_B_LSB 5
`define RC_RESET 8'h00

// level codes after decoding, and the control select codes they decode from
`define LVL_1V8 3'h0
`define LVL_2V5 3'h1
`define LVL_3V0 3'h2
`define LVL_3V3 3'h3
`define LVL_5V0 3'h4
`define SEL_2V5 3'h4
`define SEL_3V0 3'h5
`define SEL_3V3 3'h6
`define SEL_5V0 3'h7

// programming status fields
`define ST_OK 7
`define ST_RSVD 6
`define ST_LOCK 5
`define ST_SIGNATURE_EXHAUSTED 4
`define ST_DATA_EXHAUSTED 3
`define ST_HOT 2
`define ST_LV 1
`define ST_HV 0
`define ST_RESET 8'h00

// program control: bit 0 starts an attempt
`define PC_START 0

// interrupt status bits
`define IRQ_DONE 0
`define IRQ_FAIL 1
`define IRQ_WIDTH 2

`define FAIL_ADDR_RESET 16'h0000
`define ZERO8 8'h00

`endif

// ---- shared/regctl_pkg.sv ----
// types shared by the regulator control block and its bench.
// assumes regctl_regs.svh for numeric constants.
package regctl_pkg;

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_BURN = 2'b01,
    PS_DONE = 2'b10
  } prog_state_e;

  // conditions that gate an OTP programming attempt
  typedef struct packed {
    logic full_access;
    logic config_update;
    logic otp_lock_bit;
    logic sig_exhausted;
    logic data_exhausted;
    logic too_hot;
    logic stack_undervolt;
    logic stack_overvolt;
  } prog_cond_s;

  // decoded regulator outputs
  typedef struct packed {
    logic ldo_a_on;
    logic [2:0] ldo_a_level;
    logic ldo_b_on;
    logic [2:0] ldo_b_level;
  } ldo_out_s;

endpackage

// ---- rtl/regctl_block.sv ----
// regulator control register, OTP programming pre-check and outcome
// registers, with sticky interrupt status.
// assumes a single 250 MHz clock, synchronous inputs, and an external
// OTP engine that answers each burn request with a done pulse.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "regctl_regs.svh"

// What this block does
// - ldo_b level code: 0-3 1.8V, then upward
// - control bit 4 switches ldo_b
// - ldo_a level code decoded the same way
// - control bit 0 switches ldo_a
// - ok bit set alone when all conditions met
// - lock when not unrestricted+update or locked
// - signature_exhausted flag when signature writes used
// - data_exhausted flag; failing address follows
// - too_hot flag tracks temperature out of range
// - stack_undervolt flag below minimum voltage
// - stack_overvolt flag above maximum voltage
// - burn only with voltage and temperature in range
module regctl_block (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // register port
  input wire logic [`REGCTL_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // measured and mode conditions
  input wire regctl_pkg::prog_cond_s COND,
  input wire logic [15:0] FAIL_ADDR,
  // otp engine handshake
  output logic BURN_REQ,
  input wire logic BURN_DONE,
  // regulator controls
  output regctl_pkg::ldo_out_s LDO,
  // interrupt
  output logic IRQ
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] outcome;
    logic [15:0] fail_addr;
    regctl_pkg::prog_state_e state;
    logic burn_req;
    logic [`IRQ_WIDTH-1:0] irq_status;
    logic [`IRQ_WIDTH-1:0] irq_mask;
    logic irq;
    logic [7:0] rdata;
    regctl_pkg::ldo_out_s ldo;
  } state_s;

  state_s r;
  state_s next_r;
  logic [7:0] precheck;

  // level decode shared by both regulators
  function automatic logic [2:0] decode_level(input logic [2:0] sel);
    case (sel)
      `SEL_2V5: decode_level = `LVL_2V5;
      `SEL_3V0: decode_level = `LVL_3V0;
      `SEL_3V3: decode_level = `LVL_3V3;
      `SEL_5V0: decode_level = `LVL_5V0;
      default: decode_level = `LVL_1V8;
    endcase
  endfunction

  // status byte from the condition set; ok excludes all other flags
  function automatic logic [7:0] status_of(input regctl_pkg::prog_cond_s c);
    logic [7:0] s;
    s = `ST_RESET;
    s[`ST_LOCK] = !(c.full_access && c.config_update)
                  || c.otp_lock_bit;
    s[`ST_SIGNATURE_EXHAUSTED] = c.sig_exhausted;
    s[`ST_DATA_EXHAUSTED] = c.data_exhausted;
    s[`ST_HOT] = c.too_hot;
    s[`ST_LV] = c.stack_undervolt;
    s[`ST_HV] = c.stack_overvolt;
    s[`ST_RSVD] = 1'b0;
    s[`ST_OK] = (s[5:0] == 6'h00);
    status_of = s;
  endfunction

  assign precheck = status_of(COND);

  always_comb begin
    next_r = r;
    next_r.rdata = `ZERO8;
    // set wins over a write-one clear in the same cycle
    if (WR && ADDR == `OFS_IRQ_STATUS) begin
      next_r.irq_status = r.irq_status & ~WDATA[`IRQ_WIDTH-1:0];
    end
    if (WR) begin
      case (ADDR)
        `OFS_REGULATOR_CONTROL: next_r.ctrl = WDATA;
        `OFS_IRQ_MASK: next_r.irq_mask = WDATA[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
    case (r.state)
      regctl_pkg::PS_IDLE: begin
        if (WR && ADDR == `OFS_PROGRAM_CTRL && WDATA[`PC_START]) begin
          // refused attempts still produce an outcome, no burn
          if (precheck[`ST_OK]) begin
            next_r.burn_req = 1'b1;
            next_r.state = regctl_pkg::PS_BURN;
          end else begin
            next_r.state = regctl_pkg::PS_DONE;
          end
        end
      end
      regctl_pkg::PS_BURN: begin
        // abort if limits leave range during the burn
        if (BURN_DONE || precheck[`ST_HOT] || precheck[`ST_LV]
            || precheck[`ST_HV]) begin
          next_r.burn_req = 1'b0;
          next_r.state = regctl_pkg::PS_DONE;
        end
      end
      regctl_pkg::PS_DONE: begin
        next_r.outcome = precheck;
        if (precheck[`ST_DATA_EXHAUSTED]) begin
          next_r.fail_addr = FAIL_ADDR;
        end
        next_r.irq_status[`IRQ_DONE] = 1'b1;
        if (!precheck[`ST_OK]) begin
          next_r.irq_status[`IRQ_FAIL] = 1'b1;
        end
        next_r.state = regctl_pkg::PS_IDLE;
      end
      default: begin
        next_r.burn_req = 1'b0;
        next_r.state = regctl_pkg::PS_IDLE;
      end
    endcase
    if (RD) begin
      case (ADDR)
        `OFS_REGULATOR_CONTROL: next_r.rdata = r.ctrl;
        `OFS_OTP_PROGRAM_PRECHECK: next_r.rdata = precheck;
        `OFS_OTP_PROGRAM_OUTCOME: next_r.rdata = r.outcome;
        `OFS_FAIL_ADDR_LO: next_r.rdata = r.fail_addr[7:0];
        `OFS_FAIL_ADDR_HI: next_r.rdata = r.fail_addr[15:8];
        `OFS_IRQ_STATUS: next_r.rdata = {6'h00, r.irq_status};
        `OFS_IRQ_MASK: next_r.rdata = {6'h00, r.irq_mask};
        default: next_r.rdata = `ZERO8;
      endcase
    end
    next_r.ldo.ldo_b_level =
      decode_level(next_r.ctrl[`RC_LDO_B_LSB +: 3]);
    next_r.ldo.ldo_b_on = next_r.ctrl[`RC_LDO_B_ON];
    next_r.ldo.ldo_a_level =
      decode_level(next_r.ctrl[`RC_LDO_A_LSB +: 3]);
    next_r.ldo.ldo_a_on = next_r.ctrl[`RC_LDO_A_ON];
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      r <= '0;
      r.ctrl <= `RC_RESET;
      r.outcome <= `ST_RESET;
      r.fail_addr <= `FAIL_ADDR_RESET;
      r.state <= regctl_pkg::PS_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign RDATA = r.rdata;
  assign BURN_REQ = r.burn_req;
  assign LDO = r.ldo;
  assign IRQ = r.irq;

endmodule // regctl_block
`default_nettype wire

// ---- tb/otp_engine_model.sv ----
// otp engine stand-in: one done pulse per burn request.
// assumes the block holds req high until it sees done.
`timescale 1ns/1ns
`default_nettype none
module otp_engine_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic req,
  input wire logic [3:0] lat,
  output logic done
);
  logic [4:0] cnt;
  // count parks past lat, so never a second pulse
  always @(posedge clk) begin
    done <= 1'h0;
    if (srst || !req)
      cnt <= 5'h00;
    else if (cnt <= {1'h0, lat}) begin
      cnt <= cnt + 5'h01;
      done <= cnt == {1'h0, lat};
    end
  end
endmodule // otp_engine_model
`default_nettype wire

// ---- tb/regctl_block_monitor.sv ----
// port assertions for the regulator control block.
// assumes one clock and synchronous SRST.
`timescale 1ns/1ns
`default_nettype none
module regctl_block_monitor (
  // clock, reset, register port
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // conditions, engine, outputs
  input wire regctl_pkg::prog_cond_s COND,
  input wire logic [15:0] FAIL_ADDR,
  input wire logic BURN_REQ,
  input wire logic BURN_DONE,
  input wire regctl_pkg::ldo_out_s LDO,
  input wire logic IRQ
);
  wire logic wc = WR && ADDR == 8'h00;
  wire logic pre = RD && ADDR == 8'h01;
  wire logic st = RD && (ADDR == 8'h01 || ADDR == 8'h02);
  wire logic lock = !(COND[7] && COND[6]) || COND[5];
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  function automatic logic [2:0] lv(logic [2:0] c);
    return c[2] ? c - 3'h3 : 3'h0;
  endfunction
  sequence s_end;
    BURN_REQ && (BURN_DONE || COND[2:0] != 3'h0);
  endsequence
  property p_on; wc |=> LDO.ldo_a_on == $past(WDATA[0]) &&
    LDO.ldo_b_on == $past(WDATA[4]); endproperty
  a_on: assert property (p_on) else $error("ldo switch");
  property p_lvb; wc |=> LDO.ldo_b_level == lv($past(WDATA[7:5])); endproperty
  a_lvb: assert property (p_lvb) else $error("ldo_b level");
  property p_lva; wc |=> LDO.ldo_a_level == lv($past(WDATA[3:1])); endproperty
  a_lva: assert property (p_lva) else $error("ldo_a level");
  // outcome resets to all zero, so only ok-implies-clear holds for it
  property p_ok; st |=> !RDATA[7] || RDATA[6:0] == 7'h00; endproperty
  a_ok: assert property (p_ok) else $error("ok flag");
  property p_okpre; pre |=> RDATA[7] == (RDATA[6:0] == 7'h00); endproperty
  a_okpre: assert property (p_okpre) else $error("precheck ok");
  property p_lock; pre |=> RDATA[5] == $past(lock); endproperty
  a_lock: assert property (p_lock) else $error("lock flag");
  property p_flags; pre |=> RDATA[4:0] == $past(COND[4:0]); endproperty
  a_flags: assert property (p_flags) else $error("flags");
  property p_rsvd; st |=> !RDATA[6]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bit 6");
  property p_end; s_end |=> !BURN_REQ; endproperty
  a_end: assert property (p_end) else $error("burn end");
endmodule // regctl_block_monitor
bind regctl_block regctl_block_monitor u_mon (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench: integer model against the block.
// assumes checker bind and otp engine model compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0, irq, b_req, b_done;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, res;
  logic [15:0] fail_addr = 16'h0000, fa = 16'h0000;
  logic [3:0] lat = 4'h0;
  logic [1:0] st = 2'h0, mk;
  regctl_pkg::prog_cond_s cond = 8'h00;
  regctl_pkg::ldo_out_s ldo;
  int num_errors = 0, comparisons = 0, i, n;
  always #2 clk = ~clk;
  regctl_block u_dut (.CORE_CLK(clk), .SRST(srst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .COND(cond),
    .FAIL_ADDR(fail_addr), .BURN_REQ(b_req), .BURN_DONE(b_done),
    .LDO(ldo), .IRQ(irq));
  otp_engine_model u_otp (.clk(clk), .srst(srst), .req(b_req),
    .lat(lat), .done(b_done));
  function automatic logic [7:0] pre(logic [7:0] c);
    logic [5:0] f;
    f = {!(c[7] && c[6]) || c[5], c[4:0]};
    return {f == 6'h00, 1'h0, f};
  endfunction
  function automatic logic [2:0] lv(logic [2:0] c);
    return c[2] ? c - 3'h3 : 3'h0;
  endfunction
  task chk(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h, model %h", $time, seen, exp);
    end
  endtask
  task put(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task get(input logic [7:0] a, e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk(rdata, e);
  endtask
  // cut turns hot mid-burn, so the engine never gets to finish
  task burn(input logic [7:0] c, input logic cut);
    @(posedge clk);
    cond <= c;
    fail_addr <= 16'($urandom);
    lat <= cut ? 4'hF : 4'($urandom);
    put(8'h05, 8'h01);
    for (n = 0; n < 40 && (n < 3 || b_req); n++) begin
      @(posedge clk);
      if (cut && n == 2) cond[2] <= 1'h1;
      #1;
    end
    repeat (3) @(posedge clk);
    res = pre(cond);
    if (res[3]) fa = fail_addr;
    st = st | {!res[7], 1'h1};
    get(8'h02, res);
    get(8'h03, fa[7:0]);
    get(8'h04, fa[15:8]);
    get(8'h06, {6'h00, st});
    chk({7'h00, irq}, {7'h00, |(st & mk)});
  endtask
  initial begin
    v = 8'($urandom(32'hD0C115E3));
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    for (i = 0; i < 9; i++) get(8'(i), i == 1 ? 8'h20 : 8'h00);
    $display("reset test done");
    for (i = 0; i < 24; i++) begin
      v = 8'($urandom);
      v = {i[2:0], v[4], ~i[2:0], v[0]};
      put(8'h00, v);
      #1 chk(ldo, {v[0], lv(v[3:1]), v[4], lv(v[7:5])});
      get(8'h00, v);
      res = i % 4 == 0 ? 8'hC0 : 8'($urandom);
      @(posedge clk) cond <= res;
      put(8'h01, ~res);
      get(8'h01, pre(res));
    end
    $display("register test done");
    for (i = 0; i < 12; i++) begin
      mk = i[1:0];
      put(8'h07, {6'h00, mk});
      get(8'h07, {6'h00, mk});
      burn(i % 3 == 0 ? 8'hC0 : 8'($urandom), i == 3);
      put(8'h06, {6'h00, st});
      st = 2'h0;
      get(8'h06, 8'h00);
      chk({7'h00, irq}, 8'h00);
    end
    $display("program test done");
    results();
  end
  initial begin
    #20000;
    num_errors++;
    results();
  end
  task results;
    $display("%0d compares, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
endmodule // testbench
`default_nettype wire
